// file: pkg/wwd_pkg.sv
// Shared constants, types and register map of the window watchdog supervisor.
package wwd_pkg;

  // ==========================================================================
  // Timing base
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned TICK_PS       = 1000000;
  localparam int unsigned TICK_CYC      = TICK_PS / CLK_PERIOD_PS;
  localparam int unsigned CNT_W         = 24;

  // ==========================================================================
  // Times in microseconds (one tick is one microsecond)
  // ==========================================================================
  localparam int unsigned SETTLE_US       = 150;
  localparam int unsigned RST_NC_US       = 200000;
  localparam int unsigned RST_PU_US       = 10000;
  localparam int unsigned WDL_NC_00_US    = 22500;
  localparam int unsigned WDU_NC_00_US    = 55000;
  localparam int unsigned WDL_NC_10_US    = 1850;
  localparam int unsigned WDU_NC_10_US    = 27500;
  localparam int unsigned WDL_NC_11_US    = 800000;
  localparam int unsigned WDU_NC_11_US    = 1600000;
  localparam int unsigned WDL_PU_00_US    = 9000;
  localparam int unsigned WDU_PU_00_US    = 109000;
  localparam int unsigned WDL_PU_10_US    = 9000;
  localparam int unsigned WDU_PU_10_US    = 195000;
  localparam int unsigned WDL_PU_11_US    = 1850;
  localparam int unsigned WDU_PU_11_US    = 11000;
  localparam int unsigned CAP_UPPER_DEF_US = 62740;
  localparam int unsigned CAP_RST_DEF_US   = 703;

  // ==========================================================================
  // Window select codes, written as {bit1, bit0}
  // ==========================================================================
  localparam logic [1:0] SEL_RATIO_8TH  = 2'h0;
  localparam logic [1:0] SEL_DISABLE    = 2'h1;
  localparam logic [1:0] SEL_RATIO_3Q   = 2'h2;
  localparam logic [1:0] SEL_RATIO_HALF = 2'h3;

  // ==========================================================================
  // Register map (byte addresses) and fields
  // ==========================================================================
  localparam int unsigned AXI_AW     = 8;
  localparam logic [7:0]  REG_STATUS = 8'h00;
  localparam logic [7:0]  REG_IRQ    = 8'h04;
  localparam logic [7:0]  REG_MASK   = 8'h08;
  localparam logic [7:0]  REG_CAPU   = 8'h0c;
  localparam logic [7:0]  REG_CAPR   = 8'h10;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int unsigned STB_FAULT  = 0;
  localparam int unsigned STB_DIS    = 1;
  localparam int unsigned STB_SETTLE = 2;
  localparam int unsigned STB_PWRUP  = 3;
  localparam int unsigned STB_PIN    = 4;
  localparam int unsigned STB_SEL    = 5;
  localparam int unsigned STB_TOCFG  = 7;
  localparam int unsigned STB_RDCFG  = 9;
  localparam int unsigned IRQ_W       = 4;
  localparam int unsigned IRQ_TIMEOUT = 0;
  localparam int unsigned IRQ_EARLY   = 1;
  localparam int unsigned IRQ_KICK_OK = 2;
  localparam int unsigned IRQ_RELEASE = 3;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {WWD_PIN_NC, WWD_PIN_PULLUP, WWD_PIN_CAP} wwd_pincfg_e;
  typedef struct packed {
    wwd_pincfg_e timeout_cfg;
    wwd_pincfg_e delay_cfg;
  } wwd_cfg_s;
  typedef enum logic [2:0] {ST_PWRUP, ST_DISABLED, ST_SETTLE, ST_WINDOW, ST_FAULT} wwd_state_e;

endpackage

// file: hdl/wwd_kick_sync.sv
// Kick input synchroniser and falling edge detector.
`timescale 1ns/1ps
`default_nettype none
module wwd_kick_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Pin side
  input  wire logic kick_input,
  // Core side
  output logic      kick_fall
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  // Reset to high, so a line held low at start-up looks like one falling edge.
  always_comb begin
    next_meta = kick_input;
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= 1'b1;
      sync <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign kick_fall = prev & ~sync;

endmodule // wwd_kick_sync
`default_nettype wire

// file: hdl/wwd_supervisor.sv
// Window watchdog supervisor core with AXI4-Lite register access.
//
// Operation
// - Missing in-window falling kick asserts the fault.
// - Kicks ignored during power-up reset delay.
// - Kicks ignored while faulted or disabled.
// - Timeout holds fault low for reset delay.
// - Disabled watchdog keeps fault output released.
// - Straps select window ratio, timeouts or disable.
// - Timeout pin: capacitor, pull-up or open.
// - Capacitor mode derives lower bound from ratio.
// - Delay pin: capacitor, pull-up or open.
// - Fault output is active-low open drain.
// - Select bit0 high, bit1 low disables.
// - Ignore kicks 150 us after enabling.
// - Preset delays 200 ms open, 10 ms pulled.
// - Select changes apply only after fault event or re-enable.
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module wwd_supervisor #(
  parameter int unsigned TICK_DIV  = wwd_pkg::TICK_CYC,
  parameter int unsigned SETTLE_US = wwd_pkg::SETTLE_US,
  parameter int unsigned RST_NC_US = wwd_pkg::RST_NC_US,
  parameter int unsigned RST_PU_US = wwd_pkg::RST_PU_US,
  parameter int unsigned L_NC_00   = wwd_pkg::WDL_NC_00_US,
  parameter int unsigned U_NC_00   = wwd_pkg::WDU_NC_00_US,
  parameter int unsigned L_NC_10   = wwd_pkg::WDL_NC_10_US,
  parameter int unsigned U_NC_10   = wwd_pkg::WDU_NC_10_US,
  parameter int unsigned L_NC_11   = wwd_pkg::WDL_NC_11_US,
  parameter int unsigned U_NC_11   = wwd_pkg::WDU_NC_11_US,
  parameter int unsigned L_PU_00   = wwd_pkg::WDL_PU_00_US,
  parameter int unsigned U_PU_00   = wwd_pkg::WDU_PU_00_US,
  parameter int unsigned L_PU_10   = wwd_pkg::WDL_PU_10_US,
  parameter int unsigned U_PU_10   = wwd_pkg::WDU_PU_10_US,
  parameter int unsigned L_PU_11   = wwd_pkg::WDL_PU_11_US,
  parameter int unsigned U_PU_11   = wwd_pkg::WDU_PU_11_US
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        srst,
  // Watchdog pins
  input  wire logic                        kick_input,
  input  wire logic                        window_select_bit0,
  input  wire logic                        window_select_bit1,
  input  wire wwd_pkg::wwd_pincfg_e        timeout_config_pin,
  input  wire wwd_pkg::wwd_pincfg_e        reset_delay_config_pin,
  input  wire logic                        fault_out_n_i,
  output logic                             fault_out_n_o,
  output logic                             fault_out_n_oe,
  // Interrupt
  output logic                             irq,
  // AXI4-Lite slave
  input  wire logic [wwd_pkg::AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [wwd_pkg::AXI_AW-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);
  localparam int unsigned CW = wwd_pkg::CNT_W;

  // The tick divider counts in 16 bits, so larger dividers are refused.
  if (TICK_DIV < 1 || TICK_DIV > (1 << 16) || U_NC_11 >= (1 << CW)
      || RST_NC_US >= (1 << CW)) begin : g_chk
    $error("wwd_supervisor: tick divider or bounds do not fit the counter");
  end

  // ==========================================================================
  // Kick edge and microsecond tick
  // ==========================================================================
  logic                kick_fall;
  logic [15:0]         div_cnt;
  logic [15:0]         next_div_cnt;
  logic                tick;

  wwd_kick_sync u_kick (
    .clk        (clk),
    .srst       (srst),
    .kick_input (kick_input),
    .kick_fall  (kick_fall)
  );

  always_comb begin
    tick         = (div_cnt == 16'(TICK_DIV - 1));
    next_div_cnt = tick ? 16'h0000 : div_cnt + 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (srst) div_cnt <= 16'h0000;
    else      div_cnt <= next_div_cnt;
  end

  // ==========================================================================
  // Configuration decode
  // ==========================================================================
  wwd_pkg::wwd_state_e state;
  wwd_pkg::wwd_state_e next_state;
  wwd_pkg::wwd_cfg_s   cfg;
  wwd_pkg::wwd_cfg_s   next_cfg;
  logic                cfg_done;
  logic [1:0]          act_sel;
  logic [1:0]          next_act_sel;
  logic [CW-1:0]       cnt;
  logic [CW-1:0]       next_cnt;
  logic [CW-1:0]       cap_upper;
  logic [CW-1:0]       cap_rst;
  logic [CW-1:0]       lower;
  logic [CW-1:0]       upper;
  logic [CW-1:0]       rst_delay;
  logic [1:0]          live_sel;
  logic                wd_dis;
  logic [wwd_pkg::IRQ_W-1:0] ev;

  assign live_sel = {window_select_bit1, window_select_bit0};
  assign wd_dis   = cfg_done && (live_sel == wwd_pkg::SEL_DISABLE);

  always_comb begin
    case (cfg.delay_cfg)
      wwd_pkg::WWD_PIN_CAP:    rst_delay = cap_rst;
      wwd_pkg::WWD_PIN_PULLUP: rst_delay = CW'(RST_PU_US);
      default:                 rst_delay = CW'(RST_NC_US);
    endcase
    lower = CW'(L_NC_00);
    upper = CW'(U_NC_00);
    case (cfg.timeout_cfg)
      wwd_pkg::WWD_PIN_CAP: begin
        upper = cap_upper;
        case (act_sel)
          wwd_pkg::SEL_RATIO_HALF: lower = cap_upper >> 1;
          wwd_pkg::SEL_RATIO_3Q:   lower = cap_upper - (cap_upper >> 2);
          default:                 lower = cap_upper >> 3;
        endcase
      end
      wwd_pkg::WWD_PIN_PULLUP: begin
        case (act_sel)
          wwd_pkg::SEL_RATIO_HALF: begin lower = CW'(L_PU_11); upper = CW'(U_PU_11); end
          wwd_pkg::SEL_RATIO_3Q:   begin lower = CW'(L_PU_10); upper = CW'(U_PU_10); end
          default:                 begin lower = CW'(L_PU_00); upper = CW'(U_PU_00); end
        endcase
      end
      default: begin
        case (act_sel)
          wwd_pkg::SEL_RATIO_HALF: begin lower = CW'(L_NC_11); upper = CW'(U_NC_11); end
          wwd_pkg::SEL_RATIO_3Q:   begin lower = CW'(L_NC_10); upper = CW'(U_NC_10); end
          default:                 begin lower = CW'(L_NC_00); upper = CW'(U_NC_00); end
        endcase
      end
    endcase
  end

  // ==========================================================================
  // Watchdog state machine
  // ==========================================================================
  // Straps are caught on the first clock after reset, so the pins need only be
  // stable by then; later changes to the pin configuration are not seen.
  always_comb begin
    next_state   = state;
    next_cfg     = cfg;
    next_act_sel = act_sel;
    next_cnt     = (tick && cnt != {CW{1'b1}}) ? cnt + CW'(1) : cnt;
    ev           = '0;
    if (!cfg_done) begin
      next_cfg     = '{timeout_cfg: timeout_config_pin, delay_cfg: reset_delay_config_pin};
      next_act_sel = live_sel;
      next_cnt     = '0;
    end else if (wd_dis && state != wwd_pkg::ST_DISABLED) begin
      next_state = wwd_pkg::ST_DISABLED;
      next_cnt   = '0;
    end else begin
      case (state)
        wwd_pkg::ST_PWRUP: begin
          if (cnt >= rst_delay) begin
            next_state = wwd_pkg::ST_WINDOW;
            next_cnt   = '0;
          end
        end
        wwd_pkg::ST_DISABLED: begin
          next_cnt = '0;
          if (!wd_dis) begin
            next_state   = wwd_pkg::ST_SETTLE;
            next_act_sel = live_sel;
          end
        end
        wwd_pkg::ST_SETTLE: begin
          if (cnt >= CW'(SETTLE_US)) begin
            next_state = wwd_pkg::ST_WINDOW;
            next_cnt   = '0;
          end
        end
        wwd_pkg::ST_WINDOW: begin
          if (cnt >= upper || (kick_fall && cnt < lower)) begin
            next_state   = wwd_pkg::ST_FAULT;
            next_act_sel = live_sel;
            next_cnt     = '0;
            ev[wwd_pkg::IRQ_TIMEOUT] = (cnt >= upper);
            ev[wwd_pkg::IRQ_EARLY]   = (cnt < upper);
          end else if (kick_fall) begin
            next_cnt = '0;
            ev[wwd_pkg::IRQ_KICK_OK] = 1'b1;
          end
        end
        wwd_pkg::ST_FAULT: begin
          if (cnt >= rst_delay) begin
            next_state = wwd_pkg::ST_WINDOW;
            next_cnt   = '0;
            ev[wwd_pkg::IRQ_RELEASE] = 1'b1;
          end
        end
        default: next_state = wwd_pkg::ST_PWRUP;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state    <= wwd_pkg::ST_PWRUP;
      cfg      <= '{timeout_cfg: wwd_pkg::WWD_PIN_NC, delay_cfg: wwd_pkg::WWD_PIN_NC};
      cfg_done <= 1'b0;
      act_sel  <= wwd_pkg::SEL_RATIO_8TH;
      cnt      <= '0;
    end else begin
      state    <= next_state;
      cfg      <= next_cfg;
      cfg_done <= 1'b1;
      act_sel  <= next_act_sel;
      cnt      <= next_cnt;
    end
  end

  // The pin is only ever pulled low; the pull-up outside makes the high level.
  assign fault_out_n_o  = 1'b0;
  assign fault_out_n_oe = (state == wwd_pkg::ST_FAULT);

  // ==========================================================================
  // Register file and AXI4-Lite slave
  // ==========================================================================
  logic                      aw_held, w_held;
  logic                      next_aw_held, next_w_held;
  logic [wwd_pkg::AXI_AW-1:0] aw_addr, next_aw_addr;
  logic [31:0]               w_data, next_w_data;
  logic [3:0]                w_strb, next_w_strb;
  logic                      next_bvalid, next_rvalid;
  logic [1:0]                next_bresp, next_rresp;
  logic [31:0]               next_rdata, wr_val, status;
  logic [CW-1:0]             next_cap_upper, next_cap_rst;
  logic [wwd_pkg::IRQ_W-1:0] irq_stat, irq_mask, next_irq_stat, next_irq_mask;
  logic                      do_wr, do_rd;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign irq           = |(irq_stat & irq_mask);

  always_comb begin
    status = '0;
    status[wwd_pkg::STB_FAULT]  = fault_out_n_oe;
    status[wwd_pkg::STB_DIS]    = (state == wwd_pkg::ST_DISABLED);
    status[wwd_pkg::STB_SETTLE] = (state == wwd_pkg::ST_SETTLE);
    status[wwd_pkg::STB_PWRUP]  = (state == wwd_pkg::ST_PWRUP);
    status[wwd_pkg::STB_PIN]    = fault_out_n_i;
    status[wwd_pkg::STB_SEL +: 2]   = act_sel;
    status[wwd_pkg::STB_TOCFG +: 2] = cfg.timeout_cfg;
    status[wwd_pkg::STB_RDCFG +: 2] = cfg.delay_cfg;
  end

  always_comb begin
    next_aw_held = aw_held || (s_axi_awvalid && s_axi_awready);
    next_w_held  = w_held || (s_axi_wvalid && s_axi_wready);
    next_aw_addr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr;
    next_w_data  = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_data;
    next_w_strb  = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : w_strb;
    do_wr        = aw_held && w_held;
    do_rd        = s_axi_arvalid && s_axi_arready;
    next_bvalid  = s_axi_bvalid ? !s_axi_bready : do_wr;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid ? !s_axi_rready : do_rd;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    next_cap_upper = cap_upper;
    next_cap_rst   = cap_rst;
    next_irq_mask  = irq_mask;
    next_irq_stat  = irq_stat;
    wr_val = '0;
    for (int b = 0; b < 4; b++) begin
      wr_val[8*b +: 8] = w_strb[b] ? w_data[8*b +: 8] : 8'h00;
    end
    if (do_wr) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bresp   = wwd_pkg::RESP_OKAY;
      case (aw_addr)
        wwd_pkg::REG_MASK: next_irq_mask = wr_val[wwd_pkg::IRQ_W-1:0];
        wwd_pkg::REG_CAPU: next_cap_upper = wr_val[CW-1:0];
        wwd_pkg::REG_CAPR: next_cap_rst = wr_val[CW-1:0];
        wwd_pkg::REG_STATUS, wwd_pkg::REG_IRQ: ;
        default: next_bresp = wwd_pkg::RESP_SLVERR;
      endcase
    end
    if (do_rd) begin
      next_rresp = wwd_pkg::RESP_OKAY;
      next_rdata = '0;
      case (s_axi_araddr)
        wwd_pkg::REG_STATUS: next_rdata = status;
        wwd_pkg::REG_IRQ: begin
          next_rdata    = 32'(irq_stat);
          next_irq_stat = '0;
        end
        wwd_pkg::REG_MASK: next_rdata = 32'(irq_mask);
        wwd_pkg::REG_CAPU: next_rdata = 32'(cap_upper);
        wwd_pkg::REG_CAPR: next_rdata = 32'(cap_rst);
        default: next_rresp = wwd_pkg::RESP_SLVERR;
      endcase
    end
    // A new event wins over the read that clears the same bit.
    next_irq_stat = next_irq_stat | ev;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= wwd_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= wwd_pkg::RESP_OKAY;
      s_axi_rdata  <= '0;
      cap_upper <= CW'(wwd_pkg::CAP_UPPER_DEF_US);
      cap_rst   <= CW'(wwd_pkg::CAP_RST_DEF_US);
      irq_mask  <= '0;
      irq_stat  <= '0;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp  <= next_rresp;
      s_axi_rdata  <= next_rdata;
      cap_upper <= next_cap_upper;
      cap_rst   <= next_cap_rst;
      irq_mask  <= next_irq_mask;
      irq_stat  <= next_irq_stat;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_disable_release: assert property (wd_dis |=> !fault_out_n_oe)
    else $error("fault output driven while disabled");
  a_open_drain_low: assert property (fault_out_n_oe |-> fault_out_n_o == 1'b0)
    else $error("fault output driven high");
  a_timeout_fault: assert property (state == wwd_pkg::ST_WINDOW && !wd_dis && cnt >= upper
    |=> fault_out_n_oe && cnt == '0)
    else $error("no fault at upper bound");
  a_early_kick_fault: assert property (state == wwd_pkg::ST_WINDOW && !wd_dis && kick_fall
    && cnt < lower |=> state == wwd_pkg::ST_FAULT)
    else $error("early kick did not fault");
  a_kick_restart: assert property (state == wwd_pkg::ST_WINDOW && !wd_dis && kick_fall
    && cnt >= lower && cnt < upper |=> state == wwd_pkg::ST_WINDOW && cnt == '0)
    else $error("in-window kick did not restart timer");
  a_fault_ignores_kick: assert property (state == wwd_pkg::ST_FAULT && !wd_dis
    && cnt < rst_delay |=> state == wwd_pkg::ST_FAULT)
    else $error("fault released early");
  a_fault_release: assert property (state == wwd_pkg::ST_FAULT && !wd_dis && cnt >= rst_delay
    |=> state == wwd_pkg::ST_WINDOW && cnt == '0 && !fault_out_n_oe)
    else $error("fault not released after delay");
  a_settle_ignore: assert property (state == wwd_pkg::ST_SETTLE && !wd_dis
    && cnt < CW'(SETTLE_US) |=> state == wwd_pkg::ST_SETTLE)
    else $error("settle period cut short");
  a_pwrup_ignore: assert property (state == wwd_pkg::ST_PWRUP && !wd_dis && cfg_done
    && cnt < rst_delay |=> state == wwd_pkg::ST_PWRUP && !fault_out_n_oe)
    else $error("power-up delay cut short");
  a_sel_held: assert property (state == wwd_pkg::ST_WINDOW && $past(state) == wwd_pkg::ST_WINDOW
    |-> $stable(act_sel))
    else $error("window select changed without fault");
  a_disable_decode: assert property (cfg_done && live_sel == wwd_pkg::SEL_DISABLE
    |=> state == wwd_pkg::ST_DISABLED)
    else $error("disable code not honoured");

  c_timeout: cover property (state == wwd_pkg::ST_WINDOW ##1 fault_out_n_oe);
  c_kick_ok: cover property (ev[wwd_pkg::IRQ_KICK_OK]);
  c_reenable: cover property (state == wwd_pkg::ST_DISABLED ##1 state == wwd_pkg::ST_SETTLE);
  c_irq: cover property ($rose(irq));

endmodule // wwd_supervisor
`default_nettype wire

// file: dv/wwd_kicker.sv
// Partner model: the supervised processor that kicks the watchdog.
`timescale 1ns/1ps
`default_nettype none
module wwd_kicker (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Bench side
  input  wire logic kick_req,
  // Watchdog side
  output logic      kick_input
);
  logic [2:0] low_cnt;
  // Each request gives one low pulse, long enough for the synchroniser to see it.
  always_ff @(posedge clk) begin
    if (srst) begin
      low_cnt <= 3'h0;
    end else if (kick_req) begin
      low_cnt <= 3'h4;
    end else if (low_cnt != 3'h0) begin
      low_cnt <= low_cnt - 3'h1;
    end
  end
  // The line is always driven, idling high, so it never floats.
  assign kick_input = (low_cnt == 3'h0);
endmodule // wwd_kicker
`default_nettype wire

// file: dv/wwd_supervisor_tb_top.sv
// Self-checking bench of the window watchdog supervisor.
`timescale 1ns/1ps
`default_nettype none
module wwd_supervisor_tb_top;
  logic        clk = 1'b0, srst = 1'b1, kick_req = 1'b0, b0 = 1'b0, b1 = 1'b0;
  logic [3:0]  ws = 4'hf;
  wwd_pkg::wwd_pincfg_e tcfg = wwd_pkg::WWD_PIN_NC, rcfg = wwd_pkg::WWD_PIN_NC;
  logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdata, v;
  logic [1:0]  br, rr, rsp;
  logic        od, oe, irq, awr, wr, bv, arr, rv;
  wire logic   kick_input;
  int          bad_count = 0, samples_checked = 0, n;
  // The fault line has a pull-up and is only ever pulled low.
  wire logic   fault_line = oe ? od : 1'b1;
  always #4 clk = ~clk;
  wwd_kicker wwd_kicker_inst (.clk(clk), .srst(srst), .kick_req(kick_req),
    .kick_input(kick_input));
  // Short counts: one tick is two clocks, window 10..30 ticks, delay 40 ticks.
  wwd_supervisor #(.TICK_DIV(2), .SETTLE_US(8), .RST_NC_US(40), .RST_PU_US(20),
    .L_NC_00(10), .U_NC_00(30)) wwd_supervisor_inst (
    .clk(clk), .srst(srst), .kick_input(kick_input), .window_select_bit0(b0),
    .window_select_bit1(b1), .timeout_config_pin(tcfg),
    .reset_delay_config_pin(rcfg), .fault_out_n_i(fault_line),
    .fault_out_n_o(od), .fault_out_n_oe(oe), .irq(irq),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry));
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Handshakes are judged at the falling edge, then acted on at the next rising edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    logic ta, tw, hs;
    @(posedge clk);
    if (w) begin
      awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    end else begin
      ara <= a; arv <= 1'b1; rry <= 1'b1;
    end
    for (i = 0; i < 64; i++) begin
      @(negedge clk);
      ta = w ? (awv & awr) : (arv & arr);
      tw = wv & wr;
      hs = w ? bv : rv;
      if (hs) begin
        v = w ? 32'h0 : rdata; rsp = w ? br : rr;
      end
      @(posedge clk);
      if (ta) begin
        awv <= 1'b0; arv <= 1'b0;
      end
      if (tw) wv <= 1'b0;
      if (hs) break;
    end
    bry <= 1'b0; rry <= 1'b0;
    if (i == 64) begin
      bad_count++; test_done();
    end
  endtask
  task automatic kick;
    @(posedge clk); kick_req <= 1'b1;
    @(posedge clk); kick_req <= 1'b0;
  endtask
  // Bounded wait; n comes back above m when the level never came.
  task automatic wait_oe(input logic x, input int m);
    n = 0;
    while (oe !== x && n <= m) begin
      @(negedge clk); n++;
    end
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, 8'h20, 32'h0); chk(v, 32'h0); chk(rsp, wwd_pkg::RESP_SLVERR);
    bus(1'b0, wwd_pkg::REG_CAPU, 32'h0); chk(v, wwd_pkg::CAP_UPPER_DEF_US);
    bus(1'b0, wwd_pkg::REG_STATUS, 32'h0); chk(v[3], 1'b1);
    chk(v[4], 1'b1);
    kick(); wait_oe(1'b1, 300); chk(n >= 115 && n <= 140, 1'b1);
    chk(fault_line, 1'b0);
    wait_oe(1'b0, 300); chk(n >= 76 && n <= 84, 1'b1);
    bus(1'b0, wwd_pkg::REG_IRQ, 32'h0); chk(v, 32'h9);
    bus(1'b1, wwd_pkg::REG_MASK, 32'h2);
    for (int k = 0; k < 3; k++) begin
      repeat (33) @(posedge clk);
      kick();
    end
    bus(1'b0, wwd_pkg::REG_IRQ, 32'h0); chk(v, 32'h4);
    kick(); wait_oe(1'b1, 20); chk(n <= 20, 1'b1);
    repeat (2) @(negedge clk); chk(irq, 1'b1);
    bus(1'b0, wwd_pkg::REG_IRQ, 32'h0); chk(v[1], 1'b1);
    repeat (3) @(negedge clk); chk(irq, 1'b0);
    @(posedge clk); b0 <= 1'b1;
    wait_oe(1'b0, 3); chk(n <= 3, 1'b1);
    kick(); wait_oe(1'b1, 200); chk(n > 200, 1'b1);
    bus(1'b0, wwd_pkg::REG_STATUS, 32'h0); chk(v[1], 1'b1);
    @(posedge clk); b0 <= 1'b0;
    bus(1'b0, wwd_pkg::REG_STATUS, 32'h0); chk(v[2], 1'b1);
    kick(); wait_oe(1'b1, 200); chk(n >= 60 && n <= 80, 1'b1);
    // Mid-run reset: pulled-up delay pin, capacitor timeout, half ratio.
    @(posedge clk);
    srst <= 1'b1;
    b1 <= 1'b1;
    b0 <= 1'b1;
    tcfg <= wwd_pkg::WWD_PIN_CAP;
    rcfg <= wwd_pkg::WWD_PIN_PULLUP;
    repeat (6) @(posedge clk);
    chk(oe, 1'b0);
    srst <= 1'b0;
    ws <= 4'h1;
    bus(1'b1, wwd_pkg::REG_CAPU, 32'h00000328);
    bus(1'b0, wwd_pkg::REG_CAPU, 32'h0); chk(v, 32'h28);
    // Eleven ticks into the window: accepted at one eighth, early at one half.
    repeat (52) @(posedge clk);
    kick(); wait_oe(1'b1, 20); chk(n <= 20, 1'b1);
    wait_oe(1'b0, 100); chk(n >= 36 && n <= 44, 1'b1);
    bus(1'b0, wwd_pkg::REG_IRQ, 32'h0); chk(v, 32'ha);
    test_done();
  end
endmodule // wwd_supervisor_tb_top
`default_nettype wire
